// ### logic/sfq_flash_seq.sv
// Serial flash command sequencer: quad-address read, burst wrap and erase
// Summary of operation
// - Mode byte with every high bit unlike its low partner enters continuous read
// - Any matching nibble bit leaves continuous read; normal decoding from next frame
// - In continuous read a new frame starts directly with the 24-bit quad address
// - Quad read frame: address, two mode clocks, dummy clocks, then data to deselect
// - Dummy clock count comes from a control register field
// - Mode byte FFh leaves continuous read
// - Quad read arriving while busy is ignored; the running cycle goes on
// - Wrapping is off after reset
// - Wrap codes 0..3 give 8, 16, 32, 64 bytes; 1xh turns wrapping off
// - Wrapped reads stay inside the aligned block holding the start address
// - Wrap setting holds until reset or a new code; quad read uses it
// - Instruction 20h with address erases the 4K sector holding it
// - Instruction D8h with address erases the 64K block holding it
// - Instruction 52h with address erases the 32K block holding it
// - Erase acts only while the write latch flag is set
// - Erase is executed only if deselect follows exactly the last address bit
// - Erase starts at deselect; busy stands meanwhile; completion clears busy and latch
// - Protected target leaves the array alone but still clears the latch
// - Erase instructions sample line zero only
// - Quad read: instruction on one line, then address four bits per clock
//
// The strobed register port and the register offsets were chosen for this implementation.
module sfq_flash_seq #(
	parameter logic [7:0] WRITE_UNLOCK_CMD = 8'h06,
	parameter logic [7:0] SET_BURST_CMD    = 8'hc0,
	parameter int         SMALL_WIPE_CYC   = 40000,
	parameter int         MID_WIPE_CYC     = 80000,
	parameter int         LARGE_WIPE_CYC   = 120000
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_cs_n,
	input  wire logic        i_sclk,
	input  wire logic [3:0]  i_io,
	output logic      [3:0]  o_io,
	output logic      [3:0]  o_io_oe,
	input  wire logic [3:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [31:0] o_reg_rdata,
	output logic      [23:0] o_mem_addr,
	input  wire logic [7:0]  i_mem_data,
	output logic             o_wipe_req,
	output logic      [23:0] o_wipe_addr,
	output logic      [1:0]  o_wipe_kind,
	output logic             o_busy
);
	localparam int MAX_A  = (SMALL_WIPE_CYC > MID_WIPE_CYC) ? SMALL_WIPE_CYC : MID_WIPE_CYC;
	localparam int MAX_C  = (MAX_A > LARGE_WIPE_CYC) ? MAX_A : LARGE_WIPE_CYC;
	localparam int WIPE_W = $clog2(MAX_C + 1);

	if (SMALL_WIPE_CYC < 1 || MID_WIPE_CYC < 1 || LARGE_WIPE_CYC < 1) begin : g_bad_cycles
		$error("wipe cycle counts must be at least one");
	end

	typedef struct packed {
		logic                 cs_s1;
		logic                 cs_s2;
		logic                 cs_s3;
		logic                 sclk_s1;
		logic                 sclk_s2;
		logic                 sclk_s3;
		logic [3:0]           io_s1;
		logic [3:0]           io_s2;
		sfq_pkg::sfq_state_t  st;
		logic [4:0]           cnt;
		logic [7:0]           cmd;
		logic [23:0]          addr;
		logic [3:0]           mode_hi;
		logic                 cont;
		logic                 write_latch_flag;
		logic                 busy;
		logic [WIPE_W-1:0]    wipe_cnt;
		logic                 wrap_en;
		logic [1:0]           wrap_dep;
		logic                 qe;
		logic [3:0]           bp;
		logic [3:0]           dummy_cfg;
		logic [31:0]          rdata;
		logic [3:0]           io_o;
		logic [3:0]           io_oe;
		logic [23:0]          mem_addr;
		logic                 nib;
		logic                 wipe_req;
		logic [23:0]          wipe_addr;
		sfq_pkg::sfq_kind_t   wipe_kind;
	} sfq_regs_t;

	sfq_regs_t           q;
	sfq_regs_t           d;
	logic                cs_rise;
	logic                cs_fall;
	logic                sclk_rise;
	logic                sclk_fall;
	logic [7:0]          cmd_next;
	logic                is_wipe;
	sfq_pkg::sfq_kind_t  kind;
	logic [WIPE_W-1:0]   kind_cyc;
	logic [23:0]         align_mask;
	logic [8:0]          prot_cnt;
	logic [8:0]          prot_sum;
	logic                prot_hit;
	logic [23:0]         wrap_mask;
	logic [23:0]         addr_inc;
	logic [23:0]         next_addr;
	logic [31:0]         ctrl_word;
	logic [31:0]         stat_word;

	// Edges of the synchronised select and link clock
	assign cs_rise   = q.cs_s2 & ~q.cs_s3;
	assign cs_fall   = ~q.cs_s2 & q.cs_s3;
	assign sclk_rise = q.sclk_s2 & ~q.sclk_s3 & ~q.cs_s2;
	assign sclk_fall = ~q.sclk_s2 & q.sclk_s3 & ~q.cs_s2;
	assign cmd_next  = {q.cmd[6:0], q.io_s2[0]};

	// Erase kind, duration and alignment from the held instruction
	always_comb begin
		is_wipe    = 1'b1;
		kind       = sfq_pkg::KIND_SMALL;
		kind_cyc   = WIPE_W'(SMALL_WIPE_CYC);
		align_mask = ~((24'h000001 << sfq_pkg::SMALL_LSB) - 24'h000001);
		if (q.cmd == sfq_pkg::WIPE_LARGE_CMD) begin
			kind       = sfq_pkg::KIND_LARGE;
			kind_cyc   = WIPE_W'(LARGE_WIPE_CYC);
			align_mask = ~((24'h000001 << sfq_pkg::LARGE_LSB) - 24'h000001);
		end else if (q.cmd == sfq_pkg::WIPE_MID_CMD) begin
			kind       = sfq_pkg::KIND_MID;
			kind_cyc   = WIPE_W'(MID_WIPE_CYC);
			align_mask = ~((24'h000001 << sfq_pkg::MID_LSB) - 24'h000001);
		end else if (q.cmd != sfq_pkg::WIPE_SMALL_CMD) begin
			is_wipe = 1'b0;
		end
	end

	// Top blocks guarded by the block protect field
	always_comb begin
		if (q.bp == 4'h0) begin
			prot_cnt = 9'h000;
		end else if (q.bp >= sfq_pkg::PROT_ALL_LEVEL) begin
			prot_cnt = sfq_pkg::PROT_ALL_CNT;
		end else begin
			prot_cnt = 9'h001 << (q.bp - 4'h1);
		end
		prot_sum = {1'b0, q.addr[23:sfq_pkg::LARGE_LSB]} + prot_cnt;
		prot_hit = prot_sum[8];
	end

	// Sequential read address, wrapped inside the aligned block when enabled
	always_comb begin
		wrap_mask = (sfq_pkg::WRAP_MIN_SIZE << q.wrap_dep) - 24'h000001;
		addr_inc  = q.mem_addr + 24'h000001;
		next_addr = q.wrap_en ? ((q.mem_addr & ~wrap_mask) | (addr_inc & wrap_mask)) : addr_inc;
	end

	// Register read views
	always_comb begin
		ctrl_word = '0;
		ctrl_word[sfq_pkg::CTRL_QE_BIT] = q.qe;
		ctrl_word[sfq_pkg::CTRL_BP_LSB +: 4] = q.bp;
		ctrl_word[sfq_pkg::CTRL_DUMMY_LSB +: 4] = q.dummy_cfg;
		stat_word = '0;
		stat_word[sfq_pkg::STAT_BUSY_BIT] = q.busy;
		stat_word[sfq_pkg::STAT_WEL_BIT] = q.write_latch_flag;
		stat_word[sfq_pkg::STAT_CONT_BIT] = q.cont;
		stat_word[sfq_pkg::STAT_WRAP_BIT] = q.wrap_en;
		stat_word[sfq_pkg::STAT_DEPTH_LSB +: 2] = q.wrap_dep;
	end

	always_comb begin
		d = q;
		d.wipe_req = 1'b0;
		d.rdata = '0;
		d.cs_s1 = i_cs_n;
		d.cs_s2 = q.cs_s1;
		d.cs_s3 = q.cs_s2;
		d.sclk_s1 = i_sclk;
		d.sclk_s2 = q.sclk_s1;
		d.sclk_s3 = q.sclk_s2;
		d.io_s1 = i_io;
		d.io_s2 = q.io_s1;

		if (i_reg_wr && i_reg_addr == sfq_pkg::REG_CTRL) begin
			d.qe = i_reg_wdata[sfq_pkg::CTRL_QE_BIT];
			d.bp = i_reg_wdata[sfq_pkg::CTRL_BP_LSB +: 4];
			d.dummy_cfg = i_reg_wdata[sfq_pkg::CTRL_DUMMY_LSB +: 4];
		end
		if (i_reg_rd) begin
			if (i_reg_addr == sfq_pkg::REG_CTRL) begin
				d.rdata = ctrl_word;
			end else if (i_reg_addr == sfq_pkg::REG_STAT) begin
				d.rdata = stat_word;
			end
		end

		// Self-timed erase; completion drops busy and the latch together
		if (q.busy) begin
			d.wipe_cnt = q.wipe_cnt - 1'b1;
			if (q.wipe_cnt == WIPE_W'(1)) begin
				d.busy = 1'b0;
				d.write_latch_flag = 1'b0;
			end
		end

		if (cs_rise) begin
			d.st = sfq_pkg::S_IDLE;
			d.io_oe = 4'h0;
			if (q.st == sfq_pkg::S_HOLD) begin
				if (q.cmd == WRITE_UNLOCK_CMD) begin
					d.write_latch_flag = ~q.busy;
				end else if (q.cmd == SET_BURST_CMD) begin
					d.wrap_en = ~q.addr[sfq_pkg::WRAP_OFF_BIT];
					d.wrap_dep = q.addr[1:0];
				end else if (is_wipe && q.write_latch_flag && !q.busy) begin
					d.write_latch_flag = 1'b0;
					if (!prot_hit) begin
						d.write_latch_flag = 1'b1;
						d.busy = 1'b1;
						d.wipe_cnt = kind_cyc;
						d.wipe_req = 1'b1;
						d.wipe_addr = q.addr & align_mask;
						d.wipe_kind = kind;
					end
				end
			end
		end else if (cs_fall) begin
			d.st = q.cont ? sfq_pkg::S_QADR : sfq_pkg::S_CMD;
			d.cnt = 5'h00;
		end else if (sclk_rise) begin
			d.cnt = q.cnt + 5'h01;
			unique case (q.st)
				sfq_pkg::S_CMD: begin
					d.cmd = cmd_next;
					if (q.cnt == sfq_pkg::CMD_CLK_LAST) begin
						d.cnt = 5'h00;
						if (cmd_next == WRITE_UNLOCK_CMD) begin
							d.st = sfq_pkg::S_HOLD;
						end else if (cmd_next == SET_BURST_CMD) begin
							d.st = q.busy ? sfq_pkg::S_SKIP : sfq_pkg::S_WRAP;
						end else if (cmd_next == sfq_pkg::WIPE_SMALL_CMD || cmd_next == sfq_pkg::WIPE_MID_CMD ||
							cmd_next == sfq_pkg::WIPE_LARGE_CMD) begin
							d.st = q.busy ? sfq_pkg::S_SKIP : sfq_pkg::S_ADR1;
						end else if (cmd_next == sfq_pkg::QUAD_ADDR_READ_CMD) begin
							d.st = (q.busy || !q.qe) ? sfq_pkg::S_SKIP : sfq_pkg::S_QADR;
						end else begin
							d.st = sfq_pkg::S_SKIP;
						end
					end
				end
				sfq_pkg::S_ADR1: begin
					d.addr = {q.addr[22:0], q.io_s2[0]};
					if (q.cnt == sfq_pkg::ADDR1_CLK_LAST) begin
						d.st = sfq_pkg::S_HOLD;
					end
				end
				sfq_pkg::S_WRAP: begin
					d.addr = {q.addr[22:0], q.io_s2[0]};
					if (q.cnt == sfq_pkg::WRAP_CLK_LAST) begin
						d.st = sfq_pkg::S_HOLD;
					end
				end
				sfq_pkg::S_HOLD: begin
					d.st = sfq_pkg::S_SKIP;
				end
				sfq_pkg::S_QADR: begin
					d.addr = {q.addr[19:0], q.io_s2};
					if (q.cnt == sfq_pkg::QADDR_CLK_LAST) begin
						d.st = sfq_pkg::S_MODE;
						d.cnt = 5'h00;
						d.mem_addr = {q.addr[19:0], q.io_s2};
					end
				end
				sfq_pkg::S_MODE: begin
					d.mode_hi = q.io_s2;
					if (q.cnt == sfq_pkg::MODE_CLK_LAST) begin
						d.cont = &(q.mode_hi ^ q.io_s2);
						d.cnt = 5'h00;
						d.nib = 1'b0;
						d.st = (q.dummy_cfg == 4'h0) ? sfq_pkg::S_DATA : sfq_pkg::S_DUMMY;
					end
				end
				sfq_pkg::S_DUMMY: begin
					if (q.cnt == {1'b0, q.dummy_cfg} - 5'h01) begin
						d.st = sfq_pkg::S_DATA;
					end
				end
				sfq_pkg::S_IDLE, sfq_pkg::S_DATA, sfq_pkg::S_SKIP: begin
					d.cnt = q.cnt;
				end
			endcase
		end else if (sclk_fall && q.st == sfq_pkg::S_DATA) begin
			d.io_oe = 4'hf;
			d.io_o = q.nib ? i_mem_data[3:0] : i_mem_data[7:4];
			d.nib = ~q.nib;
			if (q.nib) begin
				d.mem_addr = next_addr;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			q <= '0;
			q.cs_s1 <= 1'b1;
			q.cs_s2 <= 1'b1;
			q.cs_s3 <= 1'b1;
			q.st <= sfq_pkg::S_IDLE;
			q.bp <= sfq_pkg::BP_RST;
			q.dummy_cfg <= sfq_pkg::DUMMY_RST;
			q.wrap_en <= 1'b0;
			q.wipe_kind <= sfq_pkg::KIND_SMALL;
		end else begin
			q <= d;
		end
	end

	assign o_io        = q.io_o;
	assign o_io_oe     = q.io_oe;
	assign o_reg_rdata = q.rdata;
	assign o_mem_addr  = q.mem_addr;
	assign o_wipe_req  = q.wipe_req;
	assign o_wipe_addr = q.wipe_addr;
	assign o_wipe_kind = q.wipe_kind;
	assign o_busy      = q.busy;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	property p_cont_enter;
		(q.st == sfq_pkg::S_MODE && sclk_rise && q.cnt == 5'h01 && (&(q.mode_hi ^ q.io_s2))) |=> q.cont;
	endproperty
	a_cont_enter: assert property (p_cont_enter) else $error("toggling mode byte did not set continuous read");

	property p_cont_leave;
		(q.st == sfq_pkg::S_MODE && sclk_rise && q.cnt == 5'h01 && !(&(q.mode_hi ^ q.io_s2))) |=> !q.cont;
	endproperty
	a_cont_leave: assert property (p_cont_leave) else $error("non-toggling mode byte kept continuous read");

	property p_cont_skip;
		(cs_fall && q.cont && !cs_rise) |=> q.st == sfq_pkg::S_QADR;
	endproperty
	a_cont_skip: assert property (p_cont_skip) else $error("continuous frame did not start at address");

	property p_oe_data;
		(q.io_oe != 4'h0) |-> (q.st == sfq_pkg::S_DATA && !q.cs_s3);
	endproperty
	a_oe_data: assert property (p_oe_data) else $error("lines driven outside data phase");

	property p_read_busy;
		(q.st == sfq_pkg::S_CMD && sclk_rise && q.cnt == sfq_pkg::CMD_CLK_LAST && q.busy &&
			cmd_next == sfq_pkg::QUAD_ADDR_READ_CMD) |=> (q.st == sfq_pkg::S_SKIP && q.busy);
	endproperty
	a_read_busy: assert property (p_read_busy) else $error("quad read taken while busy");

	property p_wrap_set;
		$changed(q.wrap_en) |-> ($past(cs_rise) && $past(q.st) == sfq_pkg::S_HOLD && $past(q.cmd) == SET_BURST_CMD &&
			q.wrap_en == !$past(q.addr[sfq_pkg::WRAP_OFF_BIT]));
	endproperty
	a_wrap_set: assert property (p_wrap_set) else $error("wrap setting changed without a wrap code");

	property p_wrap_block;
		(q.wrap_en && q.st == sfq_pkg::S_DATA && $changed(q.mem_addr)) |->
			(((q.mem_addr ^ $past(q.mem_addr)) & ~wrap_mask) == 24'h000000);
	endproperty
	a_wrap_block: assert property (p_wrap_block) else $error("wrapped read left its block");

	property p_wipe_align;
		q.wipe_req |-> ((q.wipe_kind == sfq_pkg::KIND_SMALL && q.wipe_addr[11:0] == 12'h000) ||
			(q.wipe_kind == sfq_pkg::KIND_MID && q.wipe_addr[14:0] == 15'h0000) ||
			(q.wipe_kind == sfq_pkg::KIND_LARGE && q.wipe_addr[15:0] == 16'h0000));
	endproperty
	a_wipe_align: assert property (p_wipe_align) else $error("erase region misaligned");

	property p_wipe_cause;
		q.wipe_req |-> ($past(q.write_latch_flag) && !$past(q.busy) && $past(q.st) == sfq_pkg::S_HOLD && $past(cs_rise) && q.busy);
	endproperty
	a_wipe_cause: assert property (p_wipe_cause) else $error("erase started without latch, exact end or idle");

	property p_done_clears;
		$fell(q.busy) |-> !q.write_latch_flag;
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("latch left set after erase");

	property p_protect;
		($past(cs_rise) && $past(q.st) == sfq_pkg::S_HOLD && $past(is_wipe) && $past(q.write_latch_flag) && !$past(q.busy) &&
			$past(prot_hit)) |-> (!q.write_latch_flag && !q.wipe_req && !q.busy);
	endproperty
	a_protect: assert property (p_protect) else $error("protected erase ran or kept latch");

	property p_no_wipe_busy;
		(q.busy && !q.wipe_req) |=> !q.wipe_req;
	endproperty
	a_no_wipe_busy: assert property (p_no_wipe_busy) else $error("erase restarted while busy");

	c_wipe: cover property (q.wipe_req);
	c_cont_frame: cover property (cs_fall && q.cont);
	c_wrap_read: cover property (q.wrap_en && q.st == sfq_pkg::S_DATA && $changed(q.mem_addr));
	c_reject: cover property (q.st == sfq_pkg::S_HOLD && sclk_rise);
endmodule

// ### logic/sfq_pkg.sv
// Constants and types shared by the serial flash command sequencer
package sfq_pkg;
	// Array address width in bits
	localparam int ADDR_W = 24;

	// Instruction codes
	localparam logic [7:0] QUAD_ADDR_READ_CMD = 8'heb;
	localparam logic [7:0] WIPE_SMALL_CMD     = 8'h20;
	localparam logic [7:0] WIPE_MID_CMD       = 8'h52;
	localparam logic [7:0] WIPE_LARGE_CMD     = 8'hd8;

	// Last index of each serial phase, counted in link clocks
	localparam logic [4:0] CMD_CLK_LAST   = 5'h07;
	localparam logic [4:0] ADDR1_CLK_LAST = 5'h17;
	localparam logic [4:0] WRAP_CLK_LAST  = 5'h07;
	localparam logic [4:0] QADDR_CLK_LAST = 5'h05;
	localparam logic [4:0] MODE_CLK_LAST  = 5'h01;

	// Register byte offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;

	// Control register fields
	localparam int CTRL_QE_BIT    = 0;
	localparam int CTRL_BP_LSB    = 4;
	localparam int CTRL_DUMMY_LSB = 8;

	// Status register fields
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_WEL_BIT    = 1;
	localparam int STAT_CONT_BIT   = 2;
	localparam int STAT_WRAP_BIT   = 3;
	localparam int STAT_DEPTH_LSB  = 4;

	// Reset values
	localparam logic [3:0] DUMMY_RST = 4'h4;
	localparam logic [3:0] BP_RST    = 4'h0;

	// Wrap code: bit 4 disables, low bits pick 8 << n bytes
	localparam int         WRAP_OFF_BIT  = 4;
	localparam logic [23:0] WRAP_MIN_SIZE = 24'h000008;

	// Erase region alignment
	localparam int SMALL_LSB = 12;
	localparam int MID_LSB   = 15;
	localparam int LARGE_LSB = 16;

	// Protection: level n guards the top 2^(n-1) 64K blocks, level 9 and up all
	localparam logic [3:0] PROT_ALL_LEVEL = 4'h9;
	localparam logic [8:0] PROT_ALL_CNT   = 9'h100;

	typedef enum logic [1:0] {
		KIND_SMALL = 2'b00,
		KIND_MID   = 2'b01,
		KIND_LARGE = 2'b10
	} sfq_kind_t;

	typedef enum logic [3:0] {
		S_IDLE  = 4'b0000,
		S_CMD   = 4'b0001,
		S_ADR1  = 4'b0010,
		S_WRAP  = 4'b0011,
		S_HOLD  = 4'b0100,
		S_QADR  = 4'b0101,
		S_MODE  = 4'b0110,
		S_DUMMY = 4'b0111,
		S_DATA  = 4'b1000,
		S_SKIP  = 4'b1001
	} sfq_state_t;
endpackage

// ### tb/sfq_host_model.sv
// Host controller model that drives select, link clock and data lines
module sfq_host_model (
	output logic            o_cs_n,
	output logic            o_sclk,
	output logic      [3:0] o_io,
	input  wire logic [3:0] i_dev_io,
	input  wire logic [3:0] i_dev_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0] h_q;

	// Released lines show the host's last driven value
	assign o_io = (i_dev_oe & i_dev_io) | (~i_dev_oe & h_q);

	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		h_q = 4'h0;
	end

	task automatic clk();
		#24 o_sclk = 1'b1;
		#24 o_sclk = 1'b0;
	endtask

	task automatic sel();
		#1.7 o_cs_n = 1'b0;
		#24;
	endtask

	task automatic desel();
		#24 o_cs_n = 1'b1;
		h_q = ~h_q;
		#240;
	endtask

	// MSB first; on one line the spare lines carry changing noise
	task automatic shift(input logic [31:0] v, input int n, input bit quad);
		for (int i = 0; i < n; i++) begin
			if (quad)
				h_q = v[4*(n-1-i) +: 4];
			else
				h_q = {~h_q[3:1], v[n-1-i]};
			clk();
		end
	endtask

	// Extra clocks after the last bit make a malformed frame
	task automatic frame(input logic [31:0] v, input int n, input int extra);
		sel();
		shift(v, n, 1'b0);
		repeat (extra) clk();
		desel();
	endtask

	task automatic rd_byte(output logic [7:0] b);
		for (int j = 0; j < 2; j++) begin
			#23 b[7-4*j -: 4] = o_io;
			#1 o_sclk = 1'b1;
			#24 o_sclk = 1'b0;
		end
	endtask

	task automatic qread(input bit cmd, input logic [23:0] a, input logic [7:0] m, input int dmy,
		output logic [7:0] q [12]);
		sel();
		if (cmd)
			shift({24'h0, sfq_pkg::QUAD_ADDR_READ_CMD}, 8, 1'b0);
		shift({a, m}, 8, 1'b1);
		h_q = ~h_q;
		repeat (dmy) clk();
		foreach (q[i]) rd_byte(q[i]);
		desel();
	endtask
endmodule

// ### tb/test_sfq_flash_seq.sv
// Self-checking bench for the serial flash command sequencer
module test_sfq_flash_seq;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		logic [7:0]  wrap;
		logic [23:0] addr;
		logic [7:0]  mode;
		logic [3:0]  dmy;
		logic        cont;
	} sfq_row_t;

	localparam logic [7:0] UNLOCK = 8'h06;
	localparam logic [7:0] BURST  = 8'hc0;

	logic        i_sys_clk = 1'b0;
	logic        i_nrst = 1'b0;
	logic        cs_n;
	logic        sclk;
	logic [3:0]  io;
	logic [3:0]  o_io;
	logic [3:0]  o_io_oe;
	logic [3:0]  i_reg_addr = 4'h0;
	logic [31:0] i_reg_wdata = 32'h0;
	logic        i_reg_wr = 1'b0;
	logic        i_reg_rd = 1'b0;
	logic [31:0] o_reg_rdata;
	logic [23:0] o_mem_addr;
	logic [7:0]  i_mem_data;
	logic        o_wipe_req;
	logic [23:0] o_wipe_addr;
	logic [1:0]  o_wipe_kind;
	logic        o_busy;
	int          fails = 0;
	int          tests_run = 0;
	int          n_req, n_busy, n_oe, t;
	logic [31:0] d;
	logic [7:0]  q [12];
	logic [7:0]  wrap_q = 8'h10;
	logic        cont = 1'b0;
	logic        en;
	logic [23:0] a, dep, v;

	sfq_row_t rows [9] = '{
		'{8'h10, 24'h00123c, 8'hff, 4'h4, 1'b0}, '{8'h01, 24'h01000e, 8'ha5, 4'h4, 1'b1},
		'{8'h00, 24'h02001d, 8'h5a, 4'h6, 1'b1}, '{8'h00, 24'h030007, 8'h0f, 4'h4, 1'b1},
		'{8'h00, 24'h040033, 8'h00, 4'h4, 1'b0}, '{8'h00, 24'h050006, 8'hf0, 4'h8, 1'b1},
		'{8'h00, 24'h06003e, 8'haa, 4'h4, 1'b0}, '{8'h03, 24'h07003a, 8'h55, 4'h4, 1'b0},
		'{8'h02, 24'h08001c, 8'hff, 4'h5, 1'b0}};
	logic [7:0] k_cmd [3] = '{sfq_pkg::WIPE_SMALL_CMD, sfq_pkg::WIPE_MID_CMD, sfq_pkg::WIPE_LARGE_CMD};
	int         k_lsb [3] = '{sfq_pkg::SMALL_LSB, sfq_pkg::MID_LSB, sfq_pkg::LARGE_LSB};
	int         k_cyc [3] = '{20, 30, 3000};

	function automatic logic [7:0] mem(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ x[23:16];
	endfunction

	assign i_mem_data = mem(o_mem_addr);

	always #2.5 i_sys_clk = ~i_sys_clk;

	sfq_flash_seq #(.WRITE_UNLOCK_CMD(UNLOCK), .SET_BURST_CMD(BURST), .SMALL_WIPE_CYC(20),
		.MID_WIPE_CYC(30), .LARGE_WIPE_CYC(3000)) i_sfq_flash_seq (
		.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cs_n(cs_n), .i_sclk(sclk), .i_io(io),
		.o_io(o_io), .o_io_oe(o_io_oe), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_mem_addr(o_mem_addr),
		.i_mem_data(i_mem_data), .o_wipe_req(o_wipe_req), .o_wipe_addr(o_wipe_addr),
		.o_wipe_kind(o_wipe_kind), .o_busy(o_busy));

	sfq_host_model i_sfq_host_model (.o_cs_n(cs_n), .o_sclk(sclk), .o_io(io), .i_dev_io(o_io),
		.i_dev_oe(o_io_oe));

	always @(posedge i_sys_clk) begin
		n_req += (o_wipe_req === 1'b1);
		n_busy += (o_busy === 1'b1);
		n_oe += (o_io_oe !== 4'h0);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [3:0] ad, input logic [31:0] wd);
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= ad;
		i_reg_wdata <= wd;
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] ad, output logic [31:0] rd);
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= ad;
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b0;
		#1 rd = o_reg_rdata;
	endtask

	task automatic reset_dut();
		@(posedge i_sys_clk);
		i_nrst <= 1'b0;
		repeat (20) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		repeat (6) @(posedge i_sys_clk);
		reg_rd(sfq_pkg::REG_STAT, d);
		chk(d, 32'h0);
		reg_rd(sfq_pkg::REG_CTRL, d);
		chk(d, {20'h0, sfq_pkg::DUMMY_RST, sfq_pkg::BP_RST, 4'h0});
	endtask

	task automatic end_sim();
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#400us;
		fails++;
		end_sim();
	end

	initial begin
		reset_dut();
		reg_wr(sfq_pkg::REG_STAT, 32'hffffffff);
		reg_wr(4'h8, 32'hffffffff);
		reg_rd(sfq_pkg::REG_STAT, d);
		chk(d, 32'h0);
		reg_rd(4'h8, d);
		chk(d, 32'h0);
		foreach (rows[r]) begin
			if (!cont) begin
				i_sfq_host_model.frame({16'h0, BURST, rows[r].wrap}, 16, 0);
				wrap_q = rows[r].wrap;
			end
			reg_wr(sfq_pkg::REG_CTRL, {20'h0, rows[r].dmy, 8'h01});
			i_sfq_host_model.qread(!cont, rows[r].addr, rows[r].mode, 32'(rows[r].dmy), q);
			en = !wrap_q[sfq_pkg::WRAP_OFF_BIT];
			dep = sfq_pkg::WRAP_MIN_SIZE << wrap_q[1:0];
			foreach (q[k]) begin
				a = rows[r].addr + 24'(k);
				if (en)
					a = (rows[r].addr & ~(dep - 24'h1)) | (a & (dep - 24'h1));
				chk(32'(q[k]), 32'(mem(a)));
			end
			cont = rows[r].cont;
			reg_rd(sfq_pkg::REG_STAT, d);
			chk(32'(d[5:0] & (en ? 6'h3f : 6'h0f)), {26'h0, wrap_q[1:0] & {2{en}}, en, cont, 2'b00});
		end
		for (int k = 0; k < 3; k++) begin
			n_req = 0;
			n_busy = 0;
			n_oe = 0;
			v = 24'h5ab6c7;
			i_sfq_host_model.frame({24'h0, UNLOCK}, 8, 0);
			reg_rd(sfq_pkg::REG_STAT, d);
			chk(32'(d[1:0]), 32'h2);
			i_sfq_host_model.frame({k_cmd[k], v}, 32, 0);
			if (k == 2) begin
				reg_rd(sfq_pkg::REG_STAT, d);
				chk(32'(d[1:0]), 32'h3);
				i_sfq_host_model.sel();
				i_sfq_host_model.shift({24'h0, sfq_pkg::QUAD_ADDR_READ_CMD}, 8, 1'b0);
				i_sfq_host_model.shift({v, 8'hff}, 8, 1'b1);
				repeat (12) i_sfq_host_model.clk();
				i_sfq_host_model.desel();
				i_sfq_host_model.frame({sfq_pkg::WIPE_SMALL_CMD, 24'h000000}, 32, 0);
				chk(32'(n_oe), 32'h0);
			end
			t = 0;
			while (o_busy !== 1'b0 && t < 4000) begin
				@(posedge i_sys_clk);
				t++;
			end
			chk(32'(n_req), 32'h1);
			chk(32'(n_busy), 32'(k_cyc[k]));
			chk(32'(o_wipe_addr), 32'(v & ~((24'h1 << k_lsb[k]) - 24'h1)));
			chk(32'(o_wipe_kind), 32'(k));
			reg_rd(sfq_pkg::REG_STAT, d);
			chk(32'(d[1:0]), 32'h0);
		end
		n_req = 0;
		n_busy = 0;
		i_sfq_host_model.frame({sfq_pkg::WIPE_SMALL_CMD, 24'h001000}, 32, 0);
		i_sfq_host_model.frame({24'h0, UNLOCK}, 8, 0);
		i_sfq_host_model.frame({1'b0, sfq_pkg::WIPE_SMALL_CMD, 23'h000800}, 31, 0);
		i_sfq_host_model.frame({sfq_pkg::WIPE_SMALL_CMD, 24'h001000}, 32, 1);
		chk(32'(n_req + n_busy), 32'h0);
		reg_wr(sfq_pkg::REG_CTRL, 32'h00000411);
		i_sfq_host_model.frame({24'h0, UNLOCK}, 8, 0);
		i_sfq_host_model.frame({sfq_pkg::WIPE_LARGE_CMD, 24'hff0123}, 32, 0);
		chk(32'(n_req + n_busy), 32'h0);
		reg_rd(sfq_pkg::REG_STAT, d);
		chk(32'(d[1:0]), 32'h0);
		i_sfq_host_model.frame({16'h0, BURST, 8'h01}, 16, 0);
		reset_dut();
		end_sim();
	end
endmodule
